/* File: rtl/egress_queue_shaper_config.sv */
// egress queue scheduling and shaper configuration for one switch port
// assumes: apb master on the same 200 MHz clock; scheduler datapath reads
// the outputs on the same clock; singleQueue comes from same-clock logic
`include "shaper_cfg_map.svh"
`default_nettype none

module egress_queue_shaper_config (
    input  wire logic        clock,
    input  wire logic        rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [13:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // from the port datapath
    input  wire logic        singleQueue,
    input  wire logic [6:0]  eventRdIndex,
    // to the scheduler and shapers
    output logic      [27:0] queueWeight,
    output logic      [3:0]  wrrActive,
    output logic      [7:0]  shaperSelect,
    output logic      [63:0] creditHighMark,
    output logic      [63:0] creditLowMark,
    output logic      [63:0] creditIncrement,
    output logic             cutThroughEnable,
    output logic             restrictedGate,
    output logic      [1:0]  referenceSelect,
    output logic      [2:0]  eventCode,
    output logic      [28:0] eventTime
);

    // ------------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------------
    shaper_cfg_pkg::bus_state_type state_reg;     // answer sequencer
    shaper_cfg_pkg::bus_state_type state_next;

    logic [1:0]  queueSel_reg;          // target queue of indexed registers
    logic [6:0]  eventIndex_reg;        // target schedule entry
    logic        cutThrough_reg;        // cut-through enable
    logic        restricted_reg;        // hold until open period
    logic [1:0]  refSel_reg;            // cycle start reference
    logic [1:0]  schedMode_reg [0:3];   // per-queue scheduler mode
    logic [1:0]  shaperSel_reg [0:3];   // per-queue shaper choice
    logic [6:0]  weight_reg    [0:3];   // per-queue wrr weight
    logic [15:0] creditHigh_reg[0:3];   // per-queue high water mark
    logic [15:0] creditLow_reg [0:3];   // per-queue low water mark
    logic [15:0] creditInc_reg [0:3];   // per-queue credit increment
    logic [3:0]  wrrActive_reg;         // registered wrr enables

    logic [31:0] prdata_reg;            // answer data
    logic [31:0] prdata_next;
    logic        pready_reg;            // answer strobe
    logic        pready_next;
    logic        pslverr_reg;           // answer error
    logic        pslverr_next;

    logic [31:0] memBusRdData;          // event entry read back
    logic [31:0] memShapeRdData;        // event entry for the shaper

    // ------------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------------
    wire [11:0] regIndex   = paddr[13:2];                // word index
    wire        aligned    = (paddr[1:0] == 2'h0);       // word aligned only
    wire        hitQSel    = aligned && (regIndex == `IDX_QUEUE_SELECT);
    wire        hitQCtrl   = aligned && (regIndex == `IDX_QUEUE_CONTROL);
    wire        hitWeight  = aligned && (regIndex == `IDX_WRR_WEIGHT);
    wire        hitHigh    = aligned && (regIndex == `IDX_CREDIT_HIGH);
    wire        hitLow     = aligned && (regIndex == `IDX_CREDIT_LOW);
    wire        hitInc     = aligned && (regIndex == `IDX_CREDIT_INC);
    wire        hitTime    = aligned && (regIndex == `IDX_TIME_CONTROL);
    wire        hitEvIdx   = aligned && (regIndex == `IDX_EVENT_INDEX);
    wire        hitEvent   = aligned && (regIndex == `IDX_EVENT_ENTRY);
    wire        mapped     = hitQSel || hitQCtrl || hitWeight || hitHigh ||
                             hitLow || hitInc || hitTime || hitEvIdx || hitEvent;

    // ------------------------------------------------------------------------
    // access qualification
    // ------------------------------------------------------------------------
    // a transfer is taken once, on the first access cycle in idle
    wire isIdle    = (state_reg == shaper_cfg_pkg::BUS_IDLE);
    wire access    = psel && penable && isIdle;
    wire wrEn      = access && pwrite && mapped;
    wire evRead    = access && !pwrite && hitEvent;
    wire evWrite   = wrEn && hitEvent;

    // ------------------------------------------------------------------------
    // read data selection for plain registers
    // ------------------------------------------------------------------------
    // indexed registers show the entry of the selected queue
    wire [1:0]  q          = queueSel_reg;
    wire [31:0] rdQSel     = {30'h0, queueSel_reg};
    wire [31:0] rdQCtrl    = {24'h0, schedMode_reg[q], shaperSel_reg[q], 4'h0};
    wire [31:0] rdWeight   = {25'h0, weight_reg[q]};
    wire [31:0] rdHigh     = {16'h0, creditHigh_reg[q]};
    wire [31:0] rdLow      = {16'h0, creditLow_reg[q]};
    wire [31:0] rdInc      = {16'h0, creditInc_reg[q]};
    wire [31:0] rdTime     = {24'h0, cutThrough_reg, restricted_reg, 4'h0, refSel_reg};
    wire [31:0] rdEvIdx    = {25'h0, eventIndex_reg};
    wire [31:0] readMux    = hitQSel   ? rdQSel   :
                             hitQCtrl  ? rdQCtrl  :
                             hitWeight ? rdWeight :
                             hitHigh   ? rdHigh   :
                             hitLow    ? rdLow    :
                             hitInc    ? rdInc    :
                             hitTime   ? rdTime   :
                             hitEvIdx  ? rdEvIdx  : 32'h0;

    // ------------------------------------------------------------------------
    // answer sequencer
    // ------------------------------------------------------------------------
    // plain registers and table writes answer after one cycle, table reads after two
    always_comb begin
        state_next   = state_reg;
        pready_next  = 1'b0;
        pslverr_next = 1'b0;
        prdata_next  = prdata_reg;
        case (state_reg)
            shaper_cfg_pkg::BUS_IDLE: begin
                if (access && evRead) begin
                    // wait for the table read
                    state_next = shaper_cfg_pkg::BUS_WAIT;
                end else if (access) begin
                    // answer now; unmapped gives error and zero
                    state_next   = shaper_cfg_pkg::BUS_DONE;
                    pready_next  = 1'b1;
                    pslverr_next = !mapped;
                    prdata_next  = pwrite ? 32'h0 : readMux;
                end
            end
            shaper_cfg_pkg::BUS_WAIT: begin
                // table data now valid
                state_next  = shaper_cfg_pkg::BUS_DONE;
                pready_next = 1'b1;
                prdata_next = memBusRdData;
            end
            shaper_cfg_pkg::BUS_DONE: begin
                // pready seen, back to idle
                state_next = shaper_cfg_pkg::BUS_IDLE;
            end
            default: begin
                state_next = shaper_cfg_pkg::BUS_IDLE;
            end
        endcase
    end

    // sequencer and answer flops
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg   <= shaper_cfg_pkg::BUS_IDLE;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0;
        end else begin
            state_reg   <= state_next;
            pready_reg  <= pready_next;
            pslverr_reg <= pslverr_next;
            prdata_reg  <= prdata_next;
        end
    end

    // ------------------------------------------------------------------------
    // port-wide registers
    // ------------------------------------------------------------------------
    // queue index
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            queueSel_reg <= `RST_QUEUE_SELECT;
        end else if (wrEn && hitQSel) begin
            queueSel_reg <= pwdata[1:0];
        end
    end

    // time shaper control
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            {cutThrough_reg, restricted_reg, refSel_reg} <= {`RST_TIME_CONTROL, 1'b0};
        end else if (wrEn && hitTime) begin
            cutThrough_reg <= pwdata[`CUT_THROUGH_BIT];
            restricted_reg <= pwdata[`RESTRICTED_BIT];
            refSel_reg     <= pwdata[`REF_SEL_HI:`REF_SEL_LO];
        end
    end

    // schedule event index
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            eventIndex_reg <= `RST_EVENT_INDEX;
        end else if (wrEn && hitEvIdx) begin
            eventIndex_reg <= pwdata[6:0];
        end
    end

    // ------------------------------------------------------------------------
    // per-queue registers
    // ------------------------------------------------------------------------
    genvar gq;
    generate
        for (gq = 0; gq < 4; gq = gq + 1) begin : g_queue
            // this queue is the one the index points to
            wire target = (queueSel_reg == 2'(gq));

            // control: scheduler mode and shaper selection
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    schedMode_reg[gq] <= `RST_SCHED_MODE;
                    shaperSel_reg[gq] <= `RST_SHAPER_SEL;
                end else if (wrEn && hitQCtrl && target) begin
                    schedMode_reg[gq] <= pwdata[`SCHED_MODE_HI:`SCHED_MODE_LO];
                    shaperSel_reg[gq] <= pwdata[`SHAPER_SEL_HI:`SHAPER_SEL_LO];
                end
            end

            // wrr weight, stored as written
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    weight_reg[gq] <= `RST_WRR_WEIGHT;
                end else if (wrEn && hitWeight && target) begin
                    weight_reg[gq] <= pwdata[6:0];
                end
            end

            // credit shaper parameters
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    creditHigh_reg[gq] <= `RST_CREDIT_HIGH;
                    creditLow_reg[gq]  <= `RST_CREDIT_LOW;
                    creditInc_reg[gq]  <= `RST_CREDIT_INC;
                end else if (wrEn && target) begin
                    if (hitHigh) begin
                        creditHigh_reg[gq] <= pwdata[15:0];
                    end
                    if (hitLow) begin
                        creditLow_reg[gq] <= pwdata[15:0];
                    end
                    if (hitInc) begin
                        creditInc_reg[gq] <= pwdata[15:0];
                    end
                end
            end

            // wrr counts only with wrr mode and more than one queue
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    wrrActive_reg[gq] <= 1'b0;
                end else begin
                    wrrActive_reg[gq] <= !singleQueue &&
                        (schedMode_reg[gq] == shaper_cfg_pkg::SCHED_WRR);
                end
            end

            // flat outputs straight from the queue flops
            assign queueWeight[gq*7 +: 7]      = weight_reg[gq];
            assign shaperSelect[gq*2 +: 2]     = shaperSel_reg[gq];
            assign creditHighMark[gq*16 +: 16] = creditHigh_reg[gq];
            assign creditLowMark[gq*16 +: 16]  = creditLow_reg[gq];
            assign creditIncrement[gq*16 +: 16] = creditInc_reg[gq];
        end
    endgenerate

    // ------------------------------------------------------------------------
    // schedule event table
    // ------------------------------------------------------------------------
    // bus side addressed by the event index, shaper side by its own index
    event_table_mem i_event_table_mem (
        .clock       (clock),
        .rst         (rst),
        .busEn       (evWrite || evRead),
        .busWrite    (evWrite),
        .busAddr     (eventIndex_reg),
        .busWrData   (pwdata),
        .busRdData   (memBusRdData),
        .shapeAddr   (eventRdIndex),
        .shapeRdData (memShapeRdData)
    );

    // event fields for the time shaper
    assign eventCode = memShapeRdData[`EVENT_CODE_HI:`EVENT_CODE_LO];
    assign eventTime = memShapeRdData[`EVENT_TIME_HI:`EVENT_TIME_LO];

    // ------------------------------------------------------------------------
    // remaining outputs
    // ------------------------------------------------------------------------
    assign prdata           = prdata_reg;
    assign pready           = pready_reg;
    assign pslverr          = pslverr_reg;
    assign wrrActive        = wrrActive_reg;
    assign cutThroughEnable = cutThrough_reg;
    assign restrictedGate   = restricted_reg;
    assign referenceSelect  = refSel_reg;

endmodule : egress_queue_shaper_config

`default_nettype wire

/* File: rtl/event_table_mem.sv */
// 128 x 32 schedule event table, one read/write port and one read port
// assumes: single clock; read data appear one edge after the enable
`default_nettype none

module event_table_mem (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        busEn,
    input  wire logic        busWrite,
    input  wire logic [6:0]  busAddr,
    input  wire logic [31:0] busWrData,
    output logic      [31:0] busRdData,
    input  wire logic [6:0]  shapeAddr,
    output logic      [31:0] shapeRdData
);

    logic [31:0] table_reg [0:127];     // event entries, no reset

    // ------------------------------------------------------------------------
    // storage and bus port
    // ------------------------------------------------------------------------
    // write on enable with write; array holds no reset
    always_ff @(posedge clock) begin
        if (busEn && busWrite) begin
            table_reg[busAddr] <= busWrData;
        end
    end

    // registered bus read data
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            busRdData <= 32'h0;
        end else if (busEn && !busWrite) begin
            busRdData <= table_reg[busAddr];
        end
    end

    // ------------------------------------------------------------------------
    // shaper read port, every cycle
    // ------------------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            shapeRdData <= 32'h0;
        end else begin
            shapeRdData <= table_reg[shapeAddr];
        end
    end

endmodule : event_table_mem

`default_nettype wire

/* File: rtl/shaper_cfg_map.svh */
// register indices, field positions, reset values of the egress shaper config
// assumes: included by bare name; byte address of a register is four times its index
`ifndef SHAPER_CFG_MAP_SVH
`define SHAPER_CFG_MAP_SVH

// ----------------------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------------------
`define IDX_QUEUE_SELECT    12'h900
`define IDX_QUEUE_CONTROL   12'h914
`define IDX_WRR_WEIGHT      12'h915
`define IDX_CREDIT_HIGH     12'h916
`define IDX_CREDIT_LOW      12'h918
`define IDX_CREDIT_INC      12'h91a
`define IDX_TIME_CONTROL    12'h920
`define IDX_EVENT_INDEX     12'h923
`define IDX_EVENT_ENTRY     12'h924

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define SCHED_MODE_HI       7
`define SCHED_MODE_LO       6
`define SHAPER_SEL_HI       5
`define SHAPER_SEL_LO       4
`define CUT_THROUGH_BIT     7
`define RESTRICTED_BIT      6
`define REF_SEL_HI          1
`define REF_SEL_LO          0
`define EVENT_CODE_HI       31
`define EVENT_CODE_LO       29
`define EVENT_TIME_HI       28
`define EVENT_TIME_LO       0

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define RST_QUEUE_SELECT    2'h0
`define RST_SCHED_MODE      2'h2
`define RST_SHAPER_SEL      2'h0
`define RST_WRR_WEIGHT      7'h01
`define RST_CREDIT_HIGH     16'h0534
`define RST_CREDIT_LOW      16'h05f2
`define RST_CREDIT_INC      16'h2000
`define RST_TIME_CONTROL    3'h0
`define RST_REF_SEL         2'h0
`define RST_EVENT_INDEX     7'h00

`endif

/* File: rtl/shaper_cfg_pkg.sv */
// types shared by the egress shaper configuration block
// assumes: compiled before every file that names these types
`default_nettype none

package shaper_cfg_pkg;

    // apb answer sequencer, gray along idle -> wait -> done
    typedef enum logic [1:0] {
        BUS_IDLE = 2'h0,
        BUS_WAIT = 2'h1,
        BUS_DONE = 2'h3
    } bus_state_type;

    // egress scheduling policy
    typedef enum logic [1:0] {
        SCHED_STRICT = 2'h0,
        SCHED_WRR    = 2'h2
    } sched_mode_type;

    // per-queue shaper selection
    typedef enum logic [1:0] {
        SHAPE_NONE   = 2'h0,
        SHAPE_CREDIT = 2'h1,
        SHAPE_TIME   = 2'h2
    } shaper_sel_type;

    // cycle start reference
    typedef enum logic [1:0] {
        REF_NONE     = 2'h0,
        REF_INTERNAL = 2'h1,
        REF_PPS      = 2'h2,
        REF_CROSSED  = 2'h3
    } ref_sel_type;

    // schedule event codes
    typedef enum logic [2:0] {
        EV_CLOSE  = 3'h0,
        EV_GUARD  = 3'h1,
        EV_OPEN   = 3'h2,
        EV_REPEAT = 3'h7
    } event_code_type;

endpackage : shaper_cfg_pkg

`default_nettype wire

/* File: tb/egress_queue_shaper_config_monitor.sv */
// port checker of the egress shaper configuration block
// assumes: bound to egress_queue_shaper_config; one clock, async reset rst
`default_nettype none

module egress_queue_shaper_config_monitor (
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        singleQueue,
    input wire logic [27:0] queueWeight,
    input wire logic [3:0]  wrrActive,
    input wire logic [7:0]  shaperSelect,
    input wire logic [63:0] creditHighMark,
    input wire logic        cutThroughEnable,
    input wire logic [1:0]  referenceSelect
);
    // ------------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    a_answer_bound: assert property (psel && penable && !pready |-> ##[1:2] pready)
        else $error("answer late");
    a_idle_quiet: assert property (!psel |=> !pready)
        else $error("ready without a request");
    a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error answer malformed");
    a_weight_read: assert property (pready && !pwrite && !pslverr && paddr == 14'h2454
        |-> prdata[31:7] == 25'h0)
        else $error("weight reserved bits not zero");
    // ------------------------------------------------------------------
    // configuration outputs move only after a write; wrr enables clear in single queue mode
    // ------------------------------------------------------------------
    a_weight_cause: assert property (!$stable(queueWeight)
        |-> $past(psel && penable && pwrite))
        else $error("weight changed without write");
    a_shaper_cause: assert property (!$stable(shaperSelect)
        |-> $past(psel && penable && pwrite))
        else $error("shaper select changed without write");
    a_credit_cause: assert property (!$stable(creditHighMark)
        |-> $past(psel && penable && pwrite))
        else $error("high mark changed without write");
    a_ref_cause: assert property (!$stable({cutThroughEnable, referenceSelect})
        |-> $past(psel && penable && pwrite))
        else $error("time control changed without write");
    a_single_wrr: assert property (singleQueue |=> wrrActive == 4'h0)
        else $error("weights active in single queue mode");
endmodule : egress_queue_shaper_config_monitor

bind egress_queue_shaper_config egress_queue_shaper_config_monitor
    i_egress_queue_shaper_config_monitor (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .singleQueue(singleQueue), .queueWeight(queueWeight), .wrrActive(wrrActive),
    .shaperSelect(shaperSelect), .creditHighMark(creditHighMark),
    .cutThroughEnable(cutThroughEnable), .referenceSelect(referenceSelect));

`default_nettype wire

/* File: tb/egress_queue_shaper_config_test.sv */
// self-checking bench of the egress shaper configuration block
// assumes: register map header on the include path; apb master below
`include "shaper_cfg_map.svh"
`default_nettype none

module egress_queue_shaper_config_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic singleQueue = 1'b0, pready, pslverr, cutThroughEnable, restrictedGate;
    logic [13:0] paddr = 14'h0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [6:0]  eventRdIndex = 7'h0;
    logic [27:0] queueWeight;
    logic [3:0]  wrrActive;
    logic [7:0]  shaperSelect;
    logic [63:0] creditHighMark, creditLowMark, creditIncrement;
    logic [1:0]  referenceSelect;
    logic [2:0]  eventCode;
    logic [28:0] eventTime;
    int          num_errors = 0, n_checks = 0;

    always #2.5 clock = ~clock;  // 200 MHz

    egress_queue_shaper_config i_egress_queue_shaper_config (
        .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .singleQueue(singleQueue), .eventRdIndex(eventRdIndex),
        .queueWeight(queueWeight), .wrrActive(wrrActive), .shaperSelect(shaperSelect),
        .creditHighMark(creditHighMark), .creditLowMark(creditLowMark),
        .creditIncrement(creditIncrement), .cutThroughEnable(cutThroughEnable),
        .restrictedGate(restrictedGate), .referenceSelect(referenceSelect),
        .eventCode(eventCode), .eventTime(eventTime));

    // ------------------------------------------------------------------
    // report, compare and bus tasks
    // ------------------------------------------------------------------
    task automatic end_of_test;
        $display("errors %0d checks %0d", num_errors, n_checks);
        if (num_errors == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_of_test

    task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", nm, exp, got);
            num_errors++;
        end
    endtask : chk

    // one transfer: setup, access held until ready sampled high
    task automatic apb(input logic wr, input logic [13:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge clock);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge clock); n++; end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin num_errors++; end_of_test(); end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    task automatic wreg(input logic [11:0] idx, input logic [31:0] d);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, {idx, 2'b00}, d, rd, err);
        chk($sformatf("write err %h", idx), 64'h0, err);
    endtask : wreg

    task automatic rreg(input logic [11:0] idx, input logic [31:0] exp);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, {idx, 2'b00}, 32'h0, rd, err);
        chk($sformatf("read err %h", idx), 64'h0, err);
        chk($sformatf("read %h", idx), exp, rd);
    endtask : rreg

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [27:0] eW;
        logic [63:0] eH, eL, eI;
        logic [7:0]  eS;
        logic [31:0] ev [4];
        logic [6:0]  ei [4];
        logic [31:0] rd;
        logic        err;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        // reset values of every queue
        for (int q = 0; q < 4; q++) begin
            wreg(`IDX_QUEUE_SELECT, q);
            rreg(`IDX_WRR_WEIGHT, 32'h01);
            rreg(`IDX_CREDIT_HIGH, 32'h0534);
            rreg(`IDX_CREDIT_LOW, 32'h05f2);
            rreg(`IDX_CREDIT_INC, 32'h2000);
            rreg(`IDX_QUEUE_CONTROL, 32'h80);
        end
        chk("weights", {4{7'h01}}, queueWeight);
        chk("wrr", 4'hf, wrrActive);
        rreg(`IDX_TIME_CONTROL, 32'h0);
        rreg(`IDX_EVENT_INDEX, 32'h0);
        // distinct values per queue, reserved bits set
        for (int q = 0; q < 4; q++) begin
            wreg(`IDX_QUEUE_SELECT, 32'hfffffffc | q);
            wreg(`IDX_WRR_WEIGHT, 32'hffffff80 | (7'h7f >> q));
            wreg(`IDX_CREDIT_HIGH, 32'hdead1000 | q);
            wreg(`IDX_CREDIT_LOW, 32'hdead2000 | q);
            wreg(`IDX_CREDIT_INC, 32'hdead3000 | q);
            wreg(`IDX_QUEUE_CONTROL, {q[0] ? 2'h2 : 2'h0, 2'(q % 3), 4'hf});
            eW[7*q+:7] = 7'h7f >> q;
            eH[16*q+:16] = 16'h1000 + q;
            eL[16*q+:16] = 16'h2000 + q;
            eI[16*q+:16] = 16'h3000 + q;
            eS[2*q+:2] = 2'(q % 3);
        end
        for (int q = 0; q < 4; q++) begin
            wreg(`IDX_QUEUE_SELECT, q);
            rreg(`IDX_WRR_WEIGHT, 7'h7f >> q);
            rreg(`IDX_CREDIT_HIGH, 16'h1000 + q);
            rreg(`IDX_CREDIT_LOW, 16'h2000 + q);
            rreg(`IDX_CREDIT_INC, 16'h3000 + q);
            rreg(`IDX_QUEUE_CONTROL, {q[0] ? 2'h2 : 2'h0, 2'(q % 3), 4'h0});
        end
        chk("weights", eW, queueWeight);
        chk("high", eH, creditHighMark);
        chk("low", eL, creditLowMark);
        chk("inc", eI, creditIncrement);
        chk("shaper", eS, shaperSelect);
        chk("wrr", 4'ha, wrrActive);
        singleQueue <= 1'b1;
        repeat (2) @(posedge clock);
        chk("wrr single", 4'h0, wrrActive);
        singleQueue <= 1'b0;
        // every reference select, both control bit values
        for (int r = 0; r < 4; r++) begin
            wreg(`IDX_TIME_CONTROL, {24'hffffff, r[1], r[0], 4'hf, r[1:0]});
            rreg(`IDX_TIME_CONTROL, {r[1], r[0], 4'h0, r[1:0]});
            chk("cut", r[1], cutThroughEnable);
            chk("restrict", r[0], restrictedGate);
            chk("ref", r[1:0], referenceSelect);
        end
        // event entries: every code, boundary indices
        ev = '{{3'h7, 29'h1fffffff}, {3'h2, 29'h0}, {3'h1, 29'h0abcdef}, {3'h0, 29'h1234567}};
        ei = '{7'h7f, 7'h00, 7'h01, 7'h40};
        for (int k = 0; k < 4; k++) begin
            wreg(`IDX_EVENT_INDEX, 32'h80 | ei[k]);
            wreg(`IDX_EVENT_ENTRY, ev[k]);
        end
        for (int k = 0; k < 4; k++) begin
            wreg(`IDX_EVENT_INDEX, ei[k]);
            rreg(`IDX_EVENT_INDEX, ei[k]);
            rreg(`IDX_EVENT_ENTRY, ev[k]);
            eventRdIndex <= ei[k];
            repeat (3) @(posedge clock);
            chk("code", ev[k][31:29], eventCode);
            chk("time", ev[k][28:0], eventTime);
        end
        // unmapped and misaligned accesses
        apb(1'b0, 14'h2404, 32'h0, rd, err);
        chk("unmapped err", 1'b1, err);
        chk("unmapped data", 32'h0, rd);
        apb(1'b1, 14'h2455, 32'h7f, rd, err);
        chk("misaligned err", 1'b1, err);
        chk("weights kept", eW, queueWeight);
        end_of_test();
    end
endmodule : egress_queue_shaper_config_test

`default_nettype wire
